//--- logic/mpps_consts.vh
// Constants for the port and pin-sharing block: offsets, fields, reset values.
// Assumes an 8-bit register port with 7-bit addresses in the low I/O page.
`ifndef MPPS_CONSTS_VH
`define MPPS_CONSTS_VH

// ****************************************
// Register offsets
// ****************************************
`define MPPS_OFF_A_DATA 7'h00
`define MPPS_OFF_B_DATA 7'h01
`define MPPS_OFF_C_DATA 7'h02
`define MPPS_OFF_D_INPUT 7'h03
`define MPPS_OFF_A_DIR 7'h04
`define MPPS_OFF_B_DIR 7'h05
`define MPPS_OFF_C_DIR 7'h06
`define MPPS_OFF_C_CMPSEL 7'h07
`define MPPS_OFF_KP_EDGE 7'h0d
`define MPPS_OFF_KP_EN 7'h0e
`define MPPS_OFF_KP_FLAG 7'h0f
`define MPPS_OFF_E_DATA 7'h40
`define MPPS_OFF_E_FAULT 7'h41
`define MPPS_OFF_F_DATA 7'h42
`define MPPS_OFF_F_FAULT 7'h43
`define MPPS_OFF_SYSCTL 7'h4d
`define MPPS_IO_PAGE_END 7'h4f

// ****************************************
// Fields
// ****************************************
`define MPPS_CMPSEL_BIT0 4
`define MPPS_CMPSEL_BIT1 5
`define MPPS_CMPSEL_MASK 8'h30
`define MPPS_SYSCTL_CLKOUT_BIT 0
`define MPPS_SYSCTL_IRQLVL_BIT 1
`define MPPS_SYSCTL_MASK 8'h03
`define MPPS_D_MASK 8'h0f
`define MPPS_F_MASK 8'h0f

// ****************************************
// Reset values
// ****************************************
`define MPPS_RST_BYTE 8'h00

`endif

//--- logic/mpps_pin_mux.v
// One 8-line bidirectional port: direction, output mux, input read-back.
// Assumes pin inputs are synchronous to the system clock.
module mpps_pin_mux #(
  parameter WIDTH = 8
) (
  input wire [WIDTH-1:0] port_data,
  input wire [WIDTH-1:0] port_dir,
  input wire [WIDTH-1:0] alt_en,
  input wire [WIDTH-1:0] alt_out,
  input wire [WIDTH-1:0] alt_oe,
  input wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] pin_out,
  output wire [WIDTH-1:0] pin_oe,
  output wire [WIDTH-1:0] read_val
);
  // Alternate function owns both level and enable of its line
  assign pin_out = (alt_en & alt_out) | (~alt_en & port_data);
  assign pin_oe = (alt_en & alt_oe) | (~alt_en & port_dir);
  // Output lines read back the latch, inputs read the pin
  assign read_val = (port_dir & port_data) | (~port_dir & pin_in);
endmodule // mpps_pin_mux

//--- logic/mpps_ports.v
// Parallel ports A to F with alternate-function sharing and keypad flags.
// Assumes one 100 MHz clock, inputs synchronous to it, byte register port.
//
// Overview of operation
// - External interrupt pin selectable falling-edge only or falling-edge plus low level.
// - Port A has eight direction-programmable lines, inputs after reset.
// - All port A lines feed the keyboard interrupt function.
// - Port B has eight programmable lines, inputs after reset.
// - Port B lines 5 to 7 carry SPI MISO, MOSI, SCK.
// - Port B line 2 can output bus clock under system control.
// - Port C has eight programmable lines, inputs after reset.
// - Port C lines 0 to 5 carry four captures and two compares.
// - Port C lines 6, 7 carry serial receive and transmit.
// - Port D is four inputs; converter selects one while active.
// - Port E is eight output lines shared with four H-bridge pairs.
// - Port F is four output lines shared with four PWM channels.
// - All registers decode within the lowest 80 byte locations.
// - Reset pin driven low on internal watchdog, power, address, voltage reset.
`include "mpps_consts.vh"

module mpps_ports #(
  parameter AW = 7
) (
  input wire CLOCK,
  input wire ARST_N,
  input wire [AW-1:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [7:0] RDATA,
  input wire [7:0] PA_IN,
  output wire [7:0] PA_OUT,
  output wire [7:0] PA_OE,
  input wire [7:0] PB_IN,
  output wire [7:0] PB_OUT,
  output wire [7:0] PB_OE,
  input wire [7:0] PC_IN,
  output wire [7:0] PC_OUT,
  output wire [7:0] PC_OE,
  input wire [3:0] PD_IN,
  output wire [7:0] PE_OUT,
  output wire [3:0] PF_OUT,
  input wire SPI_EN,
  input wire SPI_MASTER,
  input wire SPI_MISO_OUT,
  input wire SPI_MOSI_OUT,
  input wire SPI_SCK_OUT,
  output wire SPI_MISO_IN,
  output wire SPI_MOSI_IN,
  output wire SPI_SCK_IN,
  input wire BUS_CLOCK,
  output wire [3:0] TIMER_CAPTURE_INPUTS,
  input wire [1:0] TIMER_COMPARE_OUTPUTS,
  input wire SCI_RX_EN,
  input wire SCI_TX_EN,
  input wire SCI_TX_OUT,
  output wire ASYNC_RECEIVE_IN,
  input wire ADC_ACTIVE,
  input wire [1:0] ADC_CHANNEL,
  output wire [3:0] ANALOG_INPUTS,
  input wire [7:0] PWM_E_OUT,
  input wire [7:0] PWM_E_EN,
  input wire [3:0] PWM_F_OUT,
  input wire [3:0] PWM_F_EN,
  input wire [7:0] PE_FAULT_IN,
  input wire [3:0] PF_FAULT_IN,
  input wire IRQ_N_IN,
  output wire IRQ_REQ,
  output wire KEYPAD_IRQ,
  input wire RST_COP,
  input wire RST_POR,
  input wire RST_ILLADDR,
  input wire RST_LVR,
  output wire RESET_PIN_OUT,
  output wire RESET_PIN_OE
);

  // ****************************************
  // Register storage
  // ****************************************
  reg [7:0] a_data_q;
  reg [7:0] b_data_q;
  reg [7:0] c_data_q;
  reg [7:0] a_direction_bits_q;
  reg [7:0] b_dir_q;
  reg [7:0] c_dir_q;
  reg [7:0] cmpsel_q;
  reg [7:0] keypad_edge_bits_q;
  reg [7:0] keypad_enable_bits_q;
  reg [7:0] keypad_flag_bits_q;
  reg [7:0] keypad_flag_bits_d;
  reg [7:0] e_data_q;
  reg [7:0] e_fault_q;
  reg [7:0] e_fault_d;
  reg [7:0] f_data_q;
  reg [7:0] f_fault_q;
  reg [7:0] f_fault_d;
  // System control: bit0 clock out, bit1 level-sensitive interrupt
  reg [7:0] sysctl_q;
  // Previous pin samples for edge detection
  reg [7:0] pa_prev_q;
  reg irq_prev_q;
  reg [7:0] rdata_d;

  wire [7:0] a_read;
  wire [7:0] b_read;
  wire [7:0] c_read;
  wire wr_kp_flag;
  wire wr_e_fault;
  wire wr_f_fault;

  function is_addr;
    input [AW-1:0] a;
    input [6:0] off;
    begin
      is_addr = (a == off);
    end
  endfunction

  // Sticky event bits: write one clears, an event in the same cycle wins
  function [7:0] sticky_next;
    input [7:0] cur;
    input clr_en;
    input [7:0] clr_bits;
    input [7:0] set_bits;
    begin
      sticky_next = clr_en ? (cur & ~clr_bits) : cur;
      sticky_next = sticky_next | set_bits;
    end
  endfunction

  // Only the low I/O page is decoded; everything above reads zero
  wire in_page = (ADDR <= `MPPS_IO_PAGE_END);

  assign wr_kp_flag = WR && in_page && is_addr(ADDR, `MPPS_OFF_KP_FLAG);
  assign wr_e_fault = WR && in_page && is_addr(ADDR, `MPPS_OFF_E_FAULT);
  assign wr_f_fault = WR && in_page && is_addr(ADDR, `MPPS_OFF_F_FAULT);

  // ****************************************
  // Port A: plain I/O plus keypad sources
  // ****************************************
  // No alternate output on port A; the keypad only senses its pins
  mpps_pin_mux #(.WIDTH(8)) u_port_a (
    .port_data(a_data_q),
    .port_dir(a_direction_bits_q),
    .alt_en(8'h00),
    .alt_out(8'h00),
    .alt_oe(8'h00),
    .pin_in(PA_IN),
    .pin_out(PA_OUT),
    .pin_oe(PA_OE),
    .read_val(a_read)
  );

  // ****************************************
  // Port B: SPI on 5..7, bus clock on 2
  // ****************************************
  wire [7:0] b_alt_en;
  wire [7:0] b_alt_out;
  wire [7:0] b_alt_oe;
  wire clkout_en = sysctl_q[`MPPS_SYSCTL_CLKOUT_BIT];
  // Master drives MOSI and SCK, slave drives MISO
  assign b_alt_en = {SPI_EN, SPI_EN, SPI_EN, 2'b00, clkout_en, 2'b00};
  assign b_alt_out = {SPI_SCK_OUT, SPI_MOSI_OUT, SPI_MISO_OUT, 2'b00, BUS_CLOCK, 2'b00};
  assign b_alt_oe = {SPI_MASTER, SPI_MASTER, ~SPI_MASTER, 2'b00, 1'b1, 2'b00};
  assign SPI_SCK_IN = PB_IN[7];
  assign SPI_MOSI_IN = PB_IN[6];
  assign SPI_MISO_IN = PB_IN[5];

  mpps_pin_mux #(.WIDTH(8)) u_port_b (
    .port_data(b_data_q),
    .port_dir(b_dir_q),
    .alt_en(b_alt_en),
    .alt_out(b_alt_out),
    .alt_oe(b_alt_oe),
    .pin_in(PB_IN),
    .pin_out(PB_OUT),
    .pin_oe(PB_OE),
    .read_val(b_read)
  );

  // ****************************************
  // Port C: captures, compares, serial
  // ****************************************
  wire [7:0] c_alt_en;
  wire [7:0] c_alt_out;
  wire [7:0] c_alt_oe;
  wire cmp0_en = cmpsel_q[`MPPS_CMPSEL_BIT0];
  wire cmp1_en = cmpsel_q[`MPPS_CMPSEL_BIT1];
  // Captures on 0..3 always sense the pin; compares take 4 and 5 when selected
  assign c_alt_en = {SCI_TX_EN, SCI_RX_EN, cmp1_en, cmp0_en, 4'h0};
  assign TIMER_CAPTURE_INPUTS = PC_IN[3:0];
  assign ASYNC_RECEIVE_IN = PC_IN[6];
  assign c_alt_out = {SCI_TX_OUT, 1'b0, TIMER_COMPARE_OUTPUTS, 4'h0};
  // Receiver never drives its line; transmitter and compares always do
  assign c_alt_oe = 8'hb0;

  mpps_pin_mux #(.WIDTH(8)) u_port_c (
    .port_data(c_data_q),
    .port_dir(c_dir_q),
    .alt_en(c_alt_en),
    .alt_out(c_alt_out),
    .alt_oe(c_alt_oe),
    .pin_in(PC_IN),
    .pin_out(PC_OUT),
    .pin_oe(PC_OE),
    .read_val(c_read)
  );

  // ****************************************
  // Port D: analog inputs
  // ****************************************
  // Exactly one line routed while converting, none otherwise
  assign ANALOG_INPUTS = ADC_ACTIVE ? (4'h1 << ADC_CHANNEL) & PD_IN : 4'h0;

  // ****************************************
  // Ports E and F: output-only drivers
  // ****************************************
  assign PE_OUT = (PWM_E_EN & PWM_E_OUT) | (~PWM_E_EN & e_data_q);
  assign PF_OUT = (PWM_F_EN & PWM_F_OUT) | (~PWM_F_EN & f_data_q[3:0]);

  // ****************************************
  // External interrupt and reset pin
  // ****************************************
  wire irq_fall = irq_prev_q & ~IRQ_N_IN;
  wire irq_level = sysctl_q[`MPPS_SYSCTL_IRQLVL_BIT];
  assign IRQ_REQ = irq_fall | (irq_level & ~IRQ_N_IN);
  // Open-drain pulldown: only ever drives low
  assign RESET_PIN_OUT = 1'b0;
  assign RESET_PIN_OE = RST_COP | RST_POR | RST_ILLADDR | RST_LVR;

  // ****************************************
  // Keypad flags
  // ****************************************
  // Edge bit one selects rising, zero falling
  wire [7:0] pa_rise = PA_IN & ~pa_prev_q;
  wire [7:0] pa_fall = ~PA_IN & pa_prev_q;
  wire [7:0] kp_event = keypad_enable_bits_q &
    ((keypad_edge_bits_q & pa_rise) | (~keypad_edge_bits_q & pa_fall));
  assign KEYPAD_IRQ = |(keypad_flag_bits_q & keypad_enable_bits_q);

  always @* begin
    keypad_flag_bits_d = sticky_next(keypad_flag_bits_q, wr_kp_flag, WDATA, kp_event);
  end

  // ****************************************
  // Driver fault capture
  // ****************************************
  // Fault inputs are levels; latching keeps a brief short visible to software
  always @* begin
    e_fault_d = sticky_next(e_fault_q, wr_e_fault, WDATA, PE_FAULT_IN);
    f_fault_d = sticky_next(f_fault_q, wr_f_fault, WDATA, {4'h0, PF_FAULT_IN});
  end

  // ****************************************
  // Register writes
  // ****************************************
  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      a_data_q <= `MPPS_RST_BYTE;
      b_data_q <= `MPPS_RST_BYTE;
      c_data_q <= `MPPS_RST_BYTE;
      a_direction_bits_q <= `MPPS_RST_BYTE;
      b_dir_q <= `MPPS_RST_BYTE;
      c_dir_q <= `MPPS_RST_BYTE;
      cmpsel_q <= `MPPS_RST_BYTE;
      keypad_edge_bits_q <= `MPPS_RST_BYTE;
      keypad_enable_bits_q <= `MPPS_RST_BYTE;
      keypad_flag_bits_q <= `MPPS_RST_BYTE;
      e_data_q <= `MPPS_RST_BYTE;
      e_fault_q <= `MPPS_RST_BYTE;
      f_data_q <= `MPPS_RST_BYTE;
      f_fault_q <= `MPPS_RST_BYTE;
      sysctl_q <= `MPPS_RST_BYTE;
      pa_prev_q <= 8'hff;
      irq_prev_q <= 1'b1;
    end else begin
      pa_prev_q <= PA_IN;
      irq_prev_q <= IRQ_N_IN;
      keypad_flag_bits_q <= keypad_flag_bits_d;
      e_fault_q <= e_fault_d;
      f_fault_q <= f_fault_d;
      // Writes land at the strobe edge; a read sees them one cycle later
      if (WR && in_page) begin
        case (ADDR)
          `MPPS_OFF_A_DATA: a_data_q <= WDATA;
          `MPPS_OFF_B_DATA: b_data_q <= WDATA;
          `MPPS_OFF_C_DATA: c_data_q <= WDATA;
          `MPPS_OFF_A_DIR: a_direction_bits_q <= WDATA;
          `MPPS_OFF_B_DIR: b_dir_q <= WDATA;
          `MPPS_OFF_C_DIR: c_dir_q <= WDATA;
          `MPPS_OFF_C_CMPSEL: cmpsel_q <= WDATA & `MPPS_CMPSEL_MASK;
          `MPPS_OFF_KP_EDGE: keypad_edge_bits_q <= WDATA;
          `MPPS_OFF_KP_EN: keypad_enable_bits_q <= WDATA;
          `MPPS_OFF_E_DATA: e_data_q <= WDATA;
          `MPPS_OFF_F_DATA: f_data_q <= WDATA & `MPPS_F_MASK;
          `MPPS_OFF_SYSCTL: sysctl_q <= WDATA & `MPPS_SYSCTL_MASK;
          // Port D, fault and flag bytes are handled outside this decode
          default: ;
        endcase
      end
    end
  end

  // ****************************************
  // Register reads, one cycle latency
  // ****************************************
  always @* begin
    rdata_d = 8'h00;
    if (in_page) begin
      case (ADDR)
        `MPPS_OFF_A_DATA: rdata_d = a_read;
        `MPPS_OFF_B_DATA: rdata_d = b_read;
        `MPPS_OFF_C_DATA: rdata_d = c_read;
        `MPPS_OFF_D_INPUT: rdata_d = {4'h0, PD_IN};
        `MPPS_OFF_A_DIR: rdata_d = a_direction_bits_q;
        `MPPS_OFF_B_DIR: rdata_d = b_dir_q;
        `MPPS_OFF_C_DIR: rdata_d = c_dir_q;
        `MPPS_OFF_C_CMPSEL: rdata_d = cmpsel_q;
        `MPPS_OFF_KP_EDGE: rdata_d = keypad_edge_bits_q;
        `MPPS_OFF_KP_EN: rdata_d = keypad_enable_bits_q;
        `MPPS_OFF_KP_FLAG: rdata_d = keypad_flag_bits_q;
        `MPPS_OFF_E_DATA: rdata_d = e_data_q;
        `MPPS_OFF_E_FAULT: rdata_d = e_fault_q;
        `MPPS_OFF_F_DATA: rdata_d = f_data_q;
        `MPPS_OFF_F_FAULT: rdata_d = f_fault_q;
        `MPPS_OFF_SYSCTL: rdata_d = sysctl_q;
        // Unlisted offsets inside the page read zero
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Data stands only in the cycle after the read strobe
  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= RD ? rdata_d : 8'h00;
    end
  end

endmodule // mpps_ports

//--- tb/mpps_ports_sva.sv
// Checker for the port block: register read path, pin sharing, interrupt pin.
// Assumes it is bound to mpps_ports and sees only that module's ports.
module mpps_ports_sva #(
  parameter AW = 7
) (
  input wire CLOCK,
  input wire ARST_N,
  input wire [AW-1:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  input wire [7:0] RDATA,
  input wire [7:0] PA_OE,
  input wire [3:0] PD_IN,
  input wire ADC_ACTIVE,
  input wire [1:0] ADC_CHANNEL,
  input wire [3:0] ANALOG_INPUTS,
  input wire IRQ_N_IN,
  input wire IRQ_REQ,
  input wire RST_COP,
  input wire RST_POR,
  input wire RST_ILLADDR,
  input wire RST_LVR,
  input wire RESET_PIN_OUT,
  input wire RESET_PIN_OE
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);
  // ****************************************
  // Properties
  // ****************************************
  a_irq_fall_pulse: assert property ($fell(IRQ_N_IN) |-> IRQ_REQ)
    else $error("irq request missing on falling edge");
  a_irq_needs_low: assert property (IRQ_REQ |-> !IRQ_N_IN)
    else $error("irq request while pin high");
  a_reset_pin_drive: assert property (
    RESET_PIN_OE == (RST_COP | RST_POR | RST_ILLADDR | RST_LVR) && !RESET_PIN_OUT)
    else $error("reset pin drive wrong");
  a_read_idle_zero: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data outside read cycle");
  a_unmapped_read_zero: assert property (RD && ADDR > 7'h4f |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_port_d_read: assert property (RD && ADDR == 7'h03 |=> RDATA == {4'h0, $past(PD_IN)})
    else $error("port d read wrong");
  a_analog_select: assert property
    (ANALOG_INPUTS == (ADC_ACTIVE ? (PD_IN & (4'h1 << ADC_CHANNEL)) : 4'h0))
    else $error("analog select wrong");
  a_dir_write_oe: assert property (WR && ADDR == 7'h04 |=> PA_OE == $past(WDATA))
    else $error("direction write not on enables");
  a_dir_reset_input: assert property (!$past(ARST_N) |-> PA_OE == 8'h00)
    else $error("port a drives after reset");
  c_irq_seen: cover property (IRQ_REQ);
  c_port_d_read: cover property (RD && ADDR == 7'h03);
  c_reset_pin: cover property (RESET_PIN_OE);
endmodule // mpps_ports_sva

bind mpps_ports mpps_ports_sva #(.AW(AW)) u_mpps_ports_sva (.*);

//--- tb/mpps_pin_env.sv
// Outside world of one bidirectional port: loads and switches on eight lines.
// Assumes the block's enable marks the lines that it drives.
module mpps_pin_env (
  input wire [7:0] pin_out,
  input wire [7:0] pin_oe,
  input wire [7:0] ext_lvl,
  output wire [7:0] pin_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // Driven lines read back what the block drives, the rest what outside drives
  assign pin_in = (pin_out & pin_oe) | (ext_lvl & ~pin_oe);
endmodule // mpps_pin_env

//--- tb/mcu_port_pin_sharing_test.sv
// Self-checking bench for the port block through its register port and pins.
// Assumes the pin models and the checker are compiled alongside.
module mcu_port_pin_sharing_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic CLOCK, ARST_N, WR, RD, SPI_EN, SPI_MASTER, SPI_MISO_OUT, SPI_MOSI_OUT, SPI_SCK_OUT;
  logic BUS_CLOCK, SCI_RX_EN, SCI_TX_EN, SCI_TX_OUT, ADC_ACTIVE, IRQ_N_IN;
  logic RST_COP, RST_POR, RST_ILLADDR, RST_LVR;
  logic [6:0] ADDR;
  logic [7:0] WDATA, PWM_E_OUT, PWM_E_EN, PE_FAULT_IN, ea, eb, ec;
  logic [3:0] PD_IN, PWM_F_OUT, PWM_F_EN, PF_FAULT_IN;
  logic [1:0] TIMER_COMPARE_OUTPUTS, ADC_CHANNEL;
  wire [7:0] RDATA, PA_IN, PA_OUT, PA_OE, PB_IN, PB_OUT, PB_OE, PC_IN, PC_OUT, PC_OE, PE_OUT;
  wire [3:0] PF_OUT, TIMER_CAPTURE_INPUTS, ANALOG_INPUTS;
  wire SPI_MISO_IN, SPI_MOSI_IN, SPI_SCK_IN, ASYNC_RECEIVE_IN, IRQ_REQ, KEYPAD_IRQ;
  wire RESET_PIN_OUT, RESET_PIN_OE;
  wire [23:0] oe_all = {PC_OE, PB_OE, PA_OE};
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  int i;
  mpps_ports u_mpps_ports (.*);
  mpps_pin_env u_env_a (.pin_out(PA_OUT), .pin_oe(PA_OE), .ext_lvl(ea), .pin_in(PA_IN));
  mpps_pin_env u_env_b (.pin_out(PB_OUT), .pin_oe(PB_OE), .ext_lvl(eb), .pin_in(PB_IN));
  mpps_pin_env u_env_c (.pin_out(PC_OUT), .pin_oe(PC_OE), .ext_lvl(ec), .pin_in(PC_IN));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLOCK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    @(posedge CLOCK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLOCK);
    RD <= 1'b0;
    #1 chk(RDATA, exp);
  endtask
  task automatic note(input string s);
    $display("test done: %s", s);
  endtask
  task automatic report_and_stop();
    $display("checks %0d, miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end
  // Hang guard, far beyond the roughly 120 cycles the tests need
  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      report_and_stop();
    end
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {ARST_N, WR, RD, SPI_EN, SPI_MASTER, SPI_MISO_OUT, SPI_MOSI_OUT, SPI_SCK_OUT} = '0;
    {BUS_CLOCK, SCI_RX_EN, SCI_TX_EN, SCI_TX_OUT, ADC_ACTIVE, ADC_CHANNEL} = '0;
    {RST_COP, RST_POR, RST_ILLADDR, RST_LVR, ADDR, WDATA, PD_IN} = '0;
    {PWM_E_OUT, PWM_E_EN, PE_FAULT_IN, PWM_F_OUT, PWM_F_EN, PF_FAULT_IN} = '0;
    {TIMER_COMPARE_OUTPUTS, ea, eb, ec} = {2'b00, 24'h3c3c3c};
    IRQ_N_IN = 1'b1;
    repeat (10) @(posedge CLOCK);
    ARST_N <= 1'b1;
    #1 chk(oe_all[7:0], 8'h00);
    chk(oe_all[15:8], 8'h00);
    chk(oe_all[23:16], 8'h00);
    for (i = 0; i < 3; i++) rd(7'(i + 4), 8'h00);
    for (i = 0; i < 3; i++) begin
      wr(7'(i + 4), 8'hf0);
      wr(7'(i), 8'ha5);
      rd(7'(i), 8'hac);
      chk(oe_all[i*8+:8], 8'hf0);
    end
    note("direction");
    @(posedge CLOCK);
    PD_IN <= 4'ha;
    wr(7'h03, 8'hff);
    rd(7'h03, 8'h0a);
    rd(7'h50, 8'h00);
    rd(7'h0a, 8'h00);
    note("read map");
    wr(7'h04, 8'h00);
    wr(7'h0e, 8'h81);
    wr(7'h0d, 8'h01);
    wr(7'h0f, 8'hff);
    @(posedge CLOCK);
    ea <= 8'hbd;
    repeat (3) @(posedge CLOCK);
    rd(7'h0f, 8'h01);
    chk(KEYPAD_IRQ, 8'h01);
    @(posedge CLOCK);
    ea <= 8'h3c;
    repeat (3) @(posedge CLOCK);
    rd(7'h0f, 8'h81);
    wr(7'h0f, 8'hff);
    rd(7'h0f, 8'h00);
    chk(KEYPAD_IRQ, 8'h00);
    note("keypad");
    for (i = 0; i < 2; i++) begin
      wr(7'h4d, 8'(i * 2));
      @(posedge CLOCK);
      IRQ_N_IN <= 1'b0;
      #1 chk(IRQ_REQ, 8'h01);
      @(posedge CLOCK);
      #1 chk(IRQ_REQ, 8'(i));
      @(posedge CLOCK);
      IRQ_N_IN <= 1'b1;
      #1 chk(IRQ_REQ, 8'h00);
    end
    note("irq");
    wr(7'h4d, 8'h01);
    wr(7'h05, 8'h00);
    rd(7'h4d, 8'h01);
    @(posedge CLOCK);
    BUS_CLOCK <= 1'b1;
    SPI_EN <= 1'b1;
    SPI_MASTER <= 1'b1;
    SPI_SCK_OUT <= 1'b1;
    SPI_MOSI_OUT <= 1'b1;
    #1 chk({PB_OE[2], PB_OUT[2]}, 8'h03);
    chk({PB_OE[7:5], PB_OUT[7:6], SPI_MISO_IN}, 8'h37);
    @(posedge CLOCK);
    BUS_CLOCK <= 1'b0;
    SPI_MASTER <= 1'b0;
    SPI_MISO_OUT <= 1'b1;
    eb <= 8'hc0;
    #1 chk({PB_OE[2], PB_OUT[2]}, 8'h02);
    chk({PB_OE[7:5], PB_OUT[5], SPI_SCK_IN, SPI_MOSI_IN}, 8'h0f);
    note("port b sharing");
    wr(7'h06, 8'h40);
    wr(7'h07, 8'hff);
    rd(7'h07, 8'h30);
    @(posedge CLOCK);
    TIMER_COMPARE_OUTPUTS <= 2'b10;
    SCI_RX_EN <= 1'b1;
    SCI_TX_EN <= 1'b1;
    SCI_TX_OUT <= 1'b1;
    ec <= 8'h45;
    #1 chk({PC_OE[7:4], PC_OUT[7], PC_OUT[5:4]}, 8'h5e);
    chk({ASYNC_RECEIVE_IN, TIMER_CAPTURE_INPUTS}, {3'h0, ec[6], ec[3:0]});
    note("port c sharing");
    wr(7'h40, 8'h5a);
    wr(7'h42, 8'hff);
    rd(7'h42, 8'h0f);
    @(posedge CLOCK);
    PWM_E_EN <= 8'h0f;
    PWM_E_OUT <= 8'h03;
    PWM_F_EN <= 4'h3;
    PWM_F_OUT <= 4'h1;
    #1 chk(PE_OUT, 8'h53);
    chk(PF_OUT, 8'h0d);
    @(posedge CLOCK);
    PE_FAULT_IN <= 8'h11;
    PF_FAULT_IN <= 4'h6;
    @(posedge CLOCK);
    PE_FAULT_IN <= 8'h00;
    PF_FAULT_IN <= 4'h0;
    wr(7'h41, 8'h01);
    rd(7'h41, 8'h10);
    rd(7'h43, 8'h06);
    note("power outputs");
    for (i = 0; i < 5; i++) begin
      @(posedge CLOCK);
      ADC_ACTIVE <= (i < 4);
      ADC_CHANNEL <= 2'(i);
      {RST_COP, RST_POR, RST_ILLADDR, RST_LVR} <= 4'h1 << i;
      #1 chk(ANALOG_INPUTS, (i < 4) ? 8'(4'ha & (4'h1 << i)) : 8'h00);
      chk(RESET_PIN_OE, 8'(i < 4));
    end
    note("analog and reset pin");
    @(posedge CLOCK);
    ARST_N <= 1'b0;
    repeat (2) @(posedge CLOCK);
    ARST_N <= 1'b1;
    #1 chk(PA_OE, 8'h00);
    for (i = 0; i < 3; i++) rd(7'(i + 4), 8'h00);
    note("reset in mid-run");
    report_and_stop();
  end
endmodule // mcu_port_pin_sharing_test
